//--- rtl/qpfe_bank_decode.sv
`timescale 1ns/1ps
`include "qpfe_cfg.svh"

module qpfe_bank_decode (
  input wire logic bank_select_high_i,
  input wire logic bank_select_low_i,
  input wire logic [6:0] file_addr_i,
  output logic [8:0] phys_addr_o,
  output logic sfr_sel_o,
  output logic gpr_sel_o
);

  logic mirrored;
  logic common;

  // ==========================================================
  // Bank map
  always_comb begin
    // High-use registers exist once, in bank 0
    mirrored = (file_addr_i == `QPFE_MIR_INDF) || (file_addr_i == `QPFE_MIR_PCL) ||
               (file_addr_i == `QPFE_MIR_STATUS) || (file_addr_i == `QPFE_MIR_FSR) ||
               (file_addr_i == `QPFE_MIR_PCLATH) || (file_addr_i == `QPFE_MIR_INTCON);
    // Top of every bank folds onto the bank 0 RAM
    common = (file_addr_i >= `QPFE_COMMON_BASE);
    sfr_sel_o = (file_addr_i < `QPFE_SFR_TOP);
    gpr_sel_o = !sfr_sel_o;
    if (mirrored || common) begin
      phys_addr_o = {2'h0, file_addr_i};
    end else begin
      phys_addr_o = {bank_select_high_i, bank_select_low_i, file_addr_i};
    end
  end

endmodule

//--- rtl/qpfe_cfg.svh
`ifndef QPFE_CFG_SVH
`define QPFE_CFG_SVH

// ==========================================================
// Widths
`define QPFE_PC_W 13
`define QPFE_IMPL_AW 12
`define QPFE_WORD_W 14
`define QPFE_FILE_AW 7
`define QPFE_DATA_AW 9

// ==========================================================
// Vectors and reset values
`define QPFE_RESET_VEC 13'h0000
`define QPFE_IRQ_VEC 13'h0004
`define QPFE_PC_STEP 13'h0001
`define QPFE_WORD_RST 14'h0000

// ==========================================================
// Data map: bank bits sit above the 7-bit file offset
`define QPFE_SFR_TOP 7'h20
`define QPFE_COMMON_BASE 7'h70
`define QPFE_MIR_INDF 7'h00
`define QPFE_MIR_PCL 7'h02
`define QPFE_MIR_STATUS 7'h03
`define QPFE_MIR_FSR 7'h04
`define QPFE_MIR_PCLATH 7'h0a
`define QPFE_MIR_INTCON 7'h0b

`endif

//--- rtl/qpfe_core.sv
`timescale 1ns/1ps
`include "qpfe_cfg.svh"

module qpfe_core
  import qpfe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] prog_word_i,
  input wire logic branch_i,
  input wire logic [12:0] branch_target_i,
  input wire logic irq_i,
  input wire logic bank_select_high_i,
  input wire logic bank_select_low_i,
  output logic phase_one_o,
  output logic phase_two_o,
  output logic phase_three_o,
  output logic phase_four_o,
  output logic [11:0] prog_addr_o,
  output logic [12:0] pc_o,
  output logic [13:0] instr_o,
  output logic exec_valid_o,
  output logic vector_taken_o,
  output logic [12:0] ret_addr_o,
  output logic data_rd_o,
  output logic data_wr_o,
  output logic [8:0] data_addr_o,
  output logic sfr_sel_o,
  output logic gpr_sel_o
);

  qpfe_state_t s;
  qpfe_state_t next_s;
  logic [8:0] phys_addr;
  logic sfr_sel;
  logic gpr_sel;
  logic branch_take;
  logic irq_take;

  // ==========================================================
  // Data bank decode
  qpfe_bank_decode u_bank (
    .bank_select_high_i(bank_select_high_i),
    .bank_select_low_i(bank_select_low_i),
    .file_addr_i(s.ir[6:0]),
    .phys_addr_o(phys_addr),
    .sfr_sel_o(sfr_sel),
    .gpr_sel_o(gpr_sel)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    next_s = s;
    // Redirects are sampled only at the last phase, so the execution unit has phases one to four to settle
    branch_take = (s.phase == PH_FOUR) && s.exec_valid && branch_i;
    // A branch in flight wins; the interrupt waits one cycle rather than losing its target
    irq_take = (s.phase == PH_FOUR) && irq_i && !branch_take && s.primed;
    next_s.redir = 1'b0;
    next_s.vector_taken = 1'b0;
    next_s.data_rd = (s.phase == PH_ONE) && s.exec_valid;
    next_s.data_wr = (s.phase == PH_THREE) && s.exec_valid;
    next_s.data_addr = phys_addr;
    next_s.sfr_sel = sfr_sel;
    next_s.gpr_sel = gpr_sel;
    case (s.phase)
      PH_ONE: begin
        next_s.phase = PH_TWO;
      end
      PH_TWO: begin
        next_s.phase = PH_THREE;
      end
      PH_THREE: begin
        next_s.phase = PH_FOUR;
      end
      PH_FOUR: begin
        next_s.phase = PH_ONE;
        next_s.ir = prog_word_i;
        // Overlapped fetch keeps the next word ready unless it was the wrong one or the pipeline is not yet primed after reset
        next_s.exec_valid = s.primed && !branch_take && !irq_take;
        next_s.primed = 1'b1;
        if (branch_take) begin
          next_s.fetch = branch_target_i;
          next_s.pc = branch_target_i + `QPFE_PC_STEP;
          next_s.redir = 1'b1;
        end else if (irq_take) begin
          next_s.fetch = `QPFE_IRQ_VEC;
          next_s.pc = `QPFE_IRQ_VEC + `QPFE_PC_STEP;
          next_s.redir = 1'b1;
          next_s.vector_taken = 1'b1;
          // Flushed word is the one to resume at
          next_s.ret_addr = s.fetch;
        end else begin
          next_s.fetch = s.pc;
          next_s.pc = s.pc + `QPFE_PC_STEP;
        end
      end
      default: begin
        next_s.phase = PH_ONE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Parked in phase four so the first edge fetches the reset vector
      s.phase <= PH_FOUR;
      s.pc <= `QPFE_RESET_VEC;
      s.fetch <= `QPFE_RESET_VEC;
      s.ir <= `QPFE_WORD_RST;
      s.primed <= 1'b0;
      s.exec_valid <= 1'b0;
      s.redir <= 1'b0;
      s.vector_taken <= 1'b0;
      s.ret_addr <= `QPFE_RESET_VEC;
      s.data_rd <= 1'b0;
      s.data_wr <= 1'b0;
      s.data_addr <= 9'h000;
      s.sfr_sel <= 1'b0;
      s.gpr_sel <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign phase_one_o = s.phase[0];
  assign phase_two_o = s.phase[1];
  assign phase_three_o = s.phase[2];
  assign phase_four_o = s.phase[3];
  // Upper address bit ignored: the 4K array simply aliases
  assign prog_addr_o = s.fetch[11:0];
  assign pc_o = s.pc;
  assign instr_o = s.ir;
  assign exec_valid_o = s.exec_valid;
  assign vector_taken_o = s.vector_taken;
  assign ret_addr_o = s.ret_addr;
  assign data_rd_o = s.data_rd;
  assign data_wr_o = s.data_wr;
  assign data_addr_o = s.data_addr;
  assign sfr_sel_o = s.sfr_sel;
  assign gpr_sel_o = s.gpr_sel;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  phase_onehot_a: assert property ($onehot(s.phase))
    else $error("phase register not one-hot");

  phase_order_a: assert property (phase_one_o |=> phase_two_o ##1 phase_three_o ##1 phase_four_o ##1 phase_one_o)
    else $error("phases out of order");

  pc_advance_a: assert property (phase_one_o && !s.redir && $past(s.primed) |-> s.pc == $past(s.pc) + 13'h0001)
    else $error("pc did not advance by one");

  ir_capture_a: assert property (phase_four_o |=> s.ir == $past(prog_word_i))
    else $error("instruction word not captured");

  read_strobe_a: assert property (data_rd_o |-> phase_two_o && exec_valid_o && !$past(data_rd_o))
    else $error("operand read outside phase two");

  write_strobe_a: assert property (exec_valid_o && phase_three_o |=> data_wr_o && phase_four_o)
    else $error("result write missing in phase four");

  branch_flush_a: assert property (phase_four_o && exec_valid_o && branch_i |=>
                                   !exec_valid_o && prog_addr_o == $past(branch_target_i[11:0]))
    else $error("branch did not flush and redirect");

  steady_flow_a: assert property (phase_four_o && exec_valid_o && !branch_i && !irq_i |=> exec_valid_o)
    else $error("non-branch instruction stalled");

  irq_vector_a: assert property (vector_taken_o |-> prog_addr_o == 12'h004 && !exec_valid_o)
    else $error("interrupt entry not at vector");

  first_fetch_a: assert property ($past(rst_i) && !rst_i |-> prog_addr_o == 12'h000 && !exec_valid_o)
    else $error("execution before reset vector fetch");

  // Strobes must stay quiet while a flushed word sits in the pipeline
  flush_quiet_a: assert property (!exec_valid_o |-> !data_rd_o && !data_wr_o)
    else $error("data strobe in a flushed cycle");

  vector_pulse_a: assert property (vector_taken_o |=> !vector_taken_o)
    else $error("vector marker longer than one clock");

  ret_hold_a: assert property (!vector_taken_o |-> $stable(ret_addr_o))
    else $error("return address changed without interrupt entry");

  // Execute stage contents may change only on entry to phase one
  exec_stands_a: assert property (!phase_one_o |-> $stable(exec_valid_o))
    else $error("valid flag changed inside an instruction cycle");

  instr_stands_a: assert property (!phase_one_o |-> $stable(instr_o))
    else $error("instruction register changed inside an instruction cycle");

  addr_offset_a: assert property (data_rd_o |-> data_addr_o[6:0] == instr_o[6:0])
    else $error("data offset not taken from the instruction");

  bank_bits_a: assert property (data_rd_o && instr_o[6:0] < `QPFE_COMMON_BASE &&
                                !(instr_o[6:0] inside {`QPFE_MIR_INDF, `QPFE_MIR_PCL, `QPFE_MIR_STATUS,
                                `QPFE_MIR_FSR, `QPFE_MIR_PCLATH, `QPFE_MIR_INTCON}) |->
                                data_addr_o[8:7] == $past({bank_select_high_i, bank_select_low_i}))
    else $error("bank bits not applied to data address");

  // Shared registers must land in bank 0 whatever the bank bits say
  mirror_map_a: assert property (data_rd_o && (instr_o[6:0] inside {`QPFE_MIR_INDF, `QPFE_MIR_PCL,
                                 `QPFE_MIR_STATUS, `QPFE_MIR_FSR, `QPFE_MIR_PCLATH, `QPFE_MIR_INTCON}) |->
                                 data_addr_o[8:7] == 2'h0)
    else $error("shared register decoded into a bank");

  branch_c: cover property (phase_four_o && exec_valid_o && branch_i);
  irq_c: cover property (vector_taken_o);
  write_c: cover property (data_wr_o && gpr_sel_o);
  bank_c: cover property (data_rd_o && data_addr_o[8:7] == 2'h1);

endmodule

//--- rtl/qpfe_pkg.sv
package qpfe_pkg;

  typedef enum logic [3:0] {
    PH_ONE = 4'h1,
    PH_TWO = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR = 4'h8
  } qpfe_phase_t;

  typedef struct packed {
    qpfe_phase_t phase;
    logic [12:0] pc;
    logic [12:0] fetch;
    logic [13:0] ir;
    logic primed;
    logic exec_valid;
    logic redir;
    logic vector_taken;
    logic [12:0] ret_addr;
    logic data_rd;
    logic data_wr;
    logic [8:0] data_addr;
    logic sfr_sel;
    logic gpr_sel;
  } qpfe_state_t;

endpackage

//--- tb/qpfe_prog_mem.sv
`timescale 1ns/1ps
// ==========================================================
// Program memory model
module qpfe_prog_mem (
  input wire logic [11:0] addr_i,
  output logic [13:0] word_o
);
  // Combinational read, answers in the same cycle; address in the low bits
  assign word_o = {2'h1, addr_i};
endmodule

//--- tb/tb_quad_phase_fetch_execute_map.sv
`timescale 1ns/1ps
module tb_quad_phase_fetch_execute_map
  import qpfe_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] prog_word_i;
  logic branch_i = 1'b0;
  logic [12:0] branch_target_i = 13'h0000;
  logic irq_i = 1'b0;
  logic bank_select_high_i = 1'b1;
  logic bank_select_low_i = 1'b0;
  logic ph1, ph2, ph3, ph4, exv, vec, rd, wr, sfr, gpr;
  logic [11:0] paddr;
  logic [12:0] pc, ret;
  logic [13:0] instr;
  logic [8:0] daddr;
  int bad_count = 0;
  int tests_run = 0;

  qpfe_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .prog_word_i(prog_word_i), .branch_i(branch_i),
    .branch_target_i(branch_target_i), .irq_i(irq_i), .bank_select_high_i(bank_select_high_i),
    .bank_select_low_i(bank_select_low_i), .phase_one_o(ph1), .phase_two_o(ph2), .phase_three_o(ph3),
    .phase_four_o(ph4), .prog_addr_o(paddr), .pc_o(pc), .instr_o(instr), .exec_valid_o(exv),
    .vector_taken_o(vec), .ret_addr_o(ret), .data_rd_o(rd), .data_wr_o(wr), .data_addr_o(daddr),
    .sfr_sel_o(sfr), .gpr_sel_o(gpr));
  qpfe_prog_mem i_mem (.addr_i(paddr), .word_o(prog_word_i));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================
  // Helpers
  task check(input logic [13:0] seen, input logic [13:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("compares=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Returns just after the edge that enters phase three
  task to_three;
    int k;
    for (k = 0; k < 8 && ph3 !== 1'b1; k++) tick(1);
    if (ph3 !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask

  // ==========================================================
  // Scenarios
  task reset_flow;
    tick(1);
    check({ph4, ph3, ph2, ph1}, 14'h1);
    check(paddr, 14'h0);
    check(pc, 14'h1);
    check(exv, 1'b0);
    tick(1);
    check({ph4, ph3, ph2, ph1}, 14'h2);
    tick(2);
    check({ph4, ph3, ph2, ph1}, 14'h8);
    check(exv, 1'b0);
    tick(1);
    check(instr, 14'h1000);
    check(exv, 1'b1);
    check(paddr, 14'h1);
    tick(1);
    check({rd, wr}, 14'h2);
    check(daddr, 14'h000);
    check({sfr, gpr}, 14'h2);
    tick(2);
    check({rd, wr}, 14'h1);
    tick(2);
    check(instr, 14'h1001);
    check(rd, 1'b1);
    check(daddr, 14'h101);
  endtask

  task branch_flow;
    to_three();
    @(posedge clk_i);
    branch_i <= 1'b1;
    branch_target_i <= 13'h1f73;
    @(posedge clk_i);
    branch_i <= 1'b0;
    #1;
    check(paddr, 14'hf73);
    check(pc, 14'h1f74);
    check(exv, 1'b0);
    tick(1);
    check(rd, 1'b0);
    tick(3);
    check(exv, 1'b1);
    check(instr, 14'h1f73);
    tick(1);
    check(daddr, 14'h073);
    check({sfr, gpr}, 14'h1);
  endtask

  task irq_flow;
    to_three();
    @(posedge clk_i);
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    #1;
    check(paddr, 14'h004);
    check(vec, 1'b1);
    check(ret, 14'h1f74);
    check(exv, 1'b0);
    tick(4);
    check(instr, 14'h1004);
    @(posedge clk_i);
    bank_select_high_i <= 1'b0;
    bank_select_low_i <= 1'b1;
    tick(3);
    check(instr, 14'h1005);
    check(exv, 1'b1);
    tick(1);
    check(daddr, 14'h085);
    check({sfr, gpr}, 14'h2);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_flow();
    branch_flow();
    irq_flow();
    conclude();
  end
endmodule
